// file: common/dispatch_pkg.sv
package dispatch_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int POOL_DEPTH = 60;      // Waiting micro-op slots
  localparam int NUM_PORTS = 8;        // Issue ports
  localparam int MAX_DISPATCH = 8;     // Micro-ops per cycle
  localparam int NUM_SRC = 2;          // Operands per micro-op
  localparam int TAG_W_DEF = 7;        // Result tag width
  localparam int WB_N_DEF = 4;         // External writeback lanes
  localparam int LOAD_PORTS = 2;       // Loads served per cycle
  localparam int LOAD_PORT_A = 2;
  localparam int LOAD_PORT_B = 3;
  localparam int LOAD_BYTES = 32;      // Data per load micro-op
  localparam int LOAD_USE_CYC = 4;     // Fastest load-to-use
  localparam int LOAD_WAKE_STAGES = LOAD_USE_CYC - 2;
  localparam int DLY_W = 2;

  // ----------------------------------------------------------------
  // Bypass costs between stacks
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_BIT_1 = 8'h02;
  localparam logic [7:0] PORT_BIT_5 = 8'h20;
  localparam logic [7:0] PORT_BIT_6 = 8'h40;
  localparam logic [7:0] XFER_PORTS = 8'h62;
  localparam logic [1:0] DLY_INT_VEC = 2'h1;
  localparam logic [1:0] DLY_INT_LEGACY = 2'h3;
  localparam logic [1:0] DLY_LEGACY_INT = 2'h3;
  localparam logic [1:0] DLY_VEC_VEC = 2'h1;
  localparam logic [1:0] DLY_LOW_LEGACY = 2'h1;
  localparam logic [1:0] DLY_LOAD_VEC = 2'h1;
  localparam logic [1:0] DLY_LOAD_LEGACY = 2'h2;

  typedef logic [NUM_PORTS-1:0] port_mask_t;

  typedef enum logic [4:0] {
    CLS_ALU, CLS_SHIFT, CLS_JUMP, CLS_SLOW_INT, CLS_BIT_MANIP, CLS_FAST_LEA,
    CLS_LOAD, CLS_STORE_ADDR, CLS_STORE_ADDR_SIMPLE, CLS_STORE_DATA,
    CLS_VEC_LOGIC, CLS_VEC_SHIFT, CLS_VEC_ARITH, CLS_SHUFFLE, CLS_FLOAT_MOVE,
    CLS_CIPHER, CLS_VEC_MISC, CLS_FMA, CLS_FLOAT_ADD, CLS_DIVIDE
  } op_cls_e;

  typedef enum logic [2:0] {
    STK_INT, STK_VEC_INT, STK_VEC_FP_LOW, STK_LEGACY_FP, STK_LOAD
  } stack_e;

  typedef struct packed {
    port_mask_t xfer;
    logic [DLY_W-1:0] dly;
  } bypass_s;

  // Ports on which each class of micro-op may issue
  function automatic port_mask_t port_mask(input op_cls_e c);
    unique case (c)
      CLS_ALU: port_mask = 8'h63;
      CLS_SHIFT, CLS_JUMP: port_mask = 8'h41;
      CLS_SLOW_INT, CLS_FLOAT_ADD: port_mask = 8'h02;
      CLS_BIT_MANIP, CLS_FAST_LEA, CLS_VEC_ARITH: port_mask = 8'h22;
      CLS_LOAD, CLS_STORE_ADDR: port_mask = 8'h0C;
      CLS_STORE_ADDR_SIMPLE: port_mask = 8'h8C;
      CLS_STORE_DATA: port_mask = 8'h10;
      CLS_VEC_LOGIC: port_mask = 8'h23;
      CLS_VEC_SHIFT, CLS_VEC_MISC, CLS_DIVIDE: port_mask = 8'h01;
      CLS_SHUFFLE, CLS_FLOAT_MOVE, CLS_CIPHER: port_mask = 8'h20;
      CLS_FMA: port_mask = 8'h03;
      default: port_mask = 8'h00;
    endcase
  endfunction

  // Transfer micro-ops and extra cycles when a result changes stack
  function automatic bypass_s bypass_cost(input stack_e from, input stack_e to);
    bypass_s r;
    r = '0;
    unique case (from)
      STK_INT: begin
        if (to == STK_VEC_INT || to == STK_VEC_FP_LOW) r = '{PORT_BIT_5 | PORT_BIT_6, DLY_INT_VEC};
        if (to == STK_LEGACY_FP) r = '{PORT_BIT_5, DLY_INT_LEGACY};
      end
      STK_VEC_INT: begin
        if (to == STK_INT) r.xfer = PORT_BIT_1;
        if (to == STK_VEC_FP_LOW) r.dly = DLY_VEC_VEC;
      end
      STK_VEC_FP_LOW: begin
        if (to == STK_INT) r.xfer = PORT_BIT_1;
        if (to == STK_VEC_INT) r.dly = DLY_VEC_VEC;
        if (to == STK_LEGACY_FP) r = '{PORT_BIT_5, DLY_LOW_LEGACY};
      end
      STK_LEGACY_FP: begin
        if (to == STK_INT) r = '{PORT_BIT_1, DLY_LEGACY_INT};
        if (to == STK_VEC_FP_LOW) r = '{PORT_BIT_5, DLY_LOW_LEGACY};
      end
      STK_LOAD: begin
        if (to == STK_VEC_INT || to == STK_VEC_FP_LOW) r.dly = DLY_LOAD_VEC;
        if (to == STK_LEGACY_FP) r.dly = DLY_LOAD_LEGACY;
      end
      default: r = '0;
    endcase
    return r;
  endfunction

endpackage

// file: rtl/payload_store.sv
`timescale 1ns/1ps
module payload_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 60,
  parameter int RD_N = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i,                      // Core clock
  input wire logic sys_rst_i,                  // Clears read registers
  input wire logic wr_en_i,                    // Write strobe
  input wire logic [AW-1:0] wr_addr_i,         // Write slot
  input wire logic [WIDTH-1:0] wr_data_i,      // Write word
  input wire logic [RD_N-1:0][AW-1:0] rd_addr_i, // Read slots
  output logic [RD_N-1:0][WIDTH-1:0] rd_data_o   // Registered words
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset: idle read ports read slot 0 even before it is written; those words go unused
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // Read registers, one per issue port
  always_ff @(posedge clk_i) begin
    for (int r = 0; r < RD_N; r++) begin
      rd_data_o[r] <= sys_rst_i ? '0 : mem_reg[rd_addr_i[r]];
    end
  end

endmodule // payload_store

// file: rtl/uop_dispatch_port_scheduler.sv
// How it works
// - pool holds 60 micro-ops; allocation refused while every slot is full.
// - at most eight micro-ops dispatched per cycle, all operands available.
// - each micro-op leaves through exactly one port to that port's cluster.
// - integer ALU work may issue on ports 0, 1, 5, 6.
// - shifts and jumps on ports 0 and 6, primary jump on 6; the code offers every jump port 0 before port 6.
// - slow integer work issues only on port 1.
// - bit manipulation and fast address arithmetic on ports 1 and 5.
// - ports 2,3 load/store address, 4 store data, 7 simple store address.
// - vector logic on ports 0, 1, 5.
// - vector integer arithmetic on ports 1, 5; vector shifts on port 0.
// - shuffles, float moves and cipher work only on port 5.
// - miscellaneous vector work only on port 0.
// - fused multiply-add on ports 0, 1; float add only on port 1.
// - all divide and square-root work goes to port 0.
// - a result crossing stacks delays its consumer by the bypass cost.
// - some stack crossings also need an inserted transfer micro-op.
// - integer to legacy float: port 5 plus 3; to vector: ports 5,6 plus 1.
// - vector to integer: transfer on port 1; from legacy float add 3.
// - vector int/float low 1; low/legacy port 5 plus 1; loads 1 or 2.
// - two loads per cycle, 32 bytes each, four cycle load-to-use.
// - never more than one micro-op per port per cycle.
`timescale 1ns/1ps
module uop_dispatch_port_scheduler #(
  parameter int DEPTH = dispatch_pkg::POOL_DEPTH,
  parameter int TAG_W = dispatch_pkg::TAG_W_DEF,
  parameter int WB_N = dispatch_pkg::WB_N_DEF
) (
  input wire logic clk_i,                                   // Core clock
  input wire logic sys_rst_i,                               // Sync reset
  input wire logic flush_i,                                 // Pipeline flush
  input wire logic alloc_valid_i,                           // Rename offers
  output logic alloc_ready_o,                               // Pool has room
  input wire dispatch_pkg::op_cls_e alloc_cls_i,            // Operation class
  input wire dispatch_pkg::stack_e alloc_stack_i,           // Own stack
  input wire logic [TAG_W-1:0] alloc_tag_i,                 // Result tag
  input wire logic [dispatch_pkg::NUM_SRC-1:0][TAG_W-1:0] alloc_src_tag_i, // Source tags
  input wire dispatch_pkg::stack_e alloc_src_stack_i [dispatch_pkg::NUM_SRC], // Producers
  input wire logic [dispatch_pkg::NUM_SRC-1:0] alloc_src_rdy_i, // Already there
  input wire logic [WB_N-1:0] wb_valid_i,                   // Result written
  input wire logic [WB_N-1:0][TAG_W-1:0] wb_tag_i,          // Its tag
  output logic [dispatch_pkg::NUM_PORTS-1:0] port_valid_o,  // Issue per port
  output logic [dispatch_pkg::NUM_PORTS-1:0] port_xfer_o,   // Transfer micro-op
  output logic [dispatch_pkg::NUM_PORTS-1:0][TAG_W-1:0] port_tag_o, // Tag
  output dispatch_pkg::op_cls_e port_cls_o [dispatch_pkg::NUM_PORTS], // Class
  output logic [$clog2(DEPTH):0] occupancy_o                // Slots in use
);

  localparam int NP = dispatch_pkg::NUM_PORTS;
  localparam int NS = dispatch_pkg::NUM_SRC;
  localparam int IDX_W = $clog2(DEPTH);
  localparam int CNT_W = IDX_W + 1;
  localparam int BC_N = WB_N + dispatch_pkg::LOAD_PORTS;
  localparam int LW = dispatch_pkg::LOAD_WAKE_STAGES;
  localparam int CLS_W = $bits(dispatch_pkg::op_cls_e);
  localparam int PAY_W = CLS_W + TAG_W;
  localparam int DW = dispatch_pkg::DLY_W;

  if (DEPTH < NP || TAG_W < 1 || WB_N < 1 || LW < 1) begin : g_bad_cfg
    $error("Unsupported scheduler configuration");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [DEPTH-1:0] valid_reg;
  dispatch_pkg::op_cls_e cls_reg [DEPTH];
  dispatch_pkg::stack_e cstk_reg [DEPTH];
  dispatch_pkg::stack_e sstk_reg [DEPTH][NS];
  logic [NS-1:0][TAG_W-1:0] stag_reg [DEPTH];
  logic [NS-1:0] srdy_reg [DEPTH];
  dispatch_pkg::port_mask_t xfer_reg [DEPTH];
  logic [DW-1:0] dly_reg [DEPTH];
  logic [DEPTH-1:0] older_reg [DEPTH];
  logic [CNT_W-1:0] cnt_reg;
  logic ready_reg;
  logic [NP-1:0] port_valid_reg;
  logic [NP-1:0] port_xfer_reg;
  localparam int LOAD_PORTS_M1 = dispatch_pkg::LOAD_PORTS - 1;
  logic [LOAD_PORTS_M1:0] ld_v_reg [LW];
  logic [LOAD_PORTS_M1:0][TAG_W-1:0] ld_tag_reg [LW];

  // ----------------------------------------------------------------
  // Combinational signals
  // ----------------------------------------------------------------
  logic [BC_N-1:0] bc_v;
  logic [BC_N-1:0][TAG_W-1:0] bc_tag;
  logic [DEPTH-1:0] rdy_ent;
  dispatch_pkg::port_mask_t ent_mask [DEPTH];
  logic [NS-1:0] hit [DEPTH];
  dispatch_pkg::port_mask_t nx [DEPTH];
  logic [DW-1:0] dly_next [DEPTH];
  logic [DEPTH-1:0] cand;
  logic [DEPTH-1:0] taken;
  dispatch_pkg::port_mask_t xclr [DEPTH];
  logic [NP-1:0] grant_v;
  logic [NP-1:0] grant_x;
  logic [NP-1:0][IDX_W-1:0] grant_idx;
  logic [CNT_W-1:0] ndisp;
  logic [CNT_W-1:0] cnt_next;
  logic do_alloc;
  logic [IDX_W-1:0] alloc_idx;
  logic [NS-1:0] ahit;
  dispatch_pkg::port_mask_t anx;
  logic [DW-1:0] adly;
  logic [NP-1:0][PAY_W-1:0] rd_pay;

  // Tag match against every result broadcast this cycle
  function automatic logic tag_hit(input logic [TAG_W-1:0] t, input logic [BC_N-1:0] v,
                                   input logic [BC_N-1:0][TAG_W-1:0] tg);
    logic h;
    h = 1'b0;
    for (int b = 0; b < BC_N; b++) begin
      h = h | (v[b] && tg[b] == t);
    end
    return h;
  endfunction

  // Broadcasts: external writeback plus the load wake pipe
  always_comb begin
    bc_v = {ld_v_reg[LW-1], wb_valid_i};
    bc_tag = {ld_tag_reg[LW-1], wb_tag_i};
  end

  // Per-slot readiness and allowed ports
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    assign ent_mask[i] = dispatch_pkg::port_mask(cls_reg[i]);
    assign rdy_ent[i] = valid_reg[i] && (&srdy_reg[i]) && xfer_reg[i] == '0
                        && dly_reg[i] == '0;
  end

  // Wake-up with bypass cost of the crossing
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      dispatch_pkg::bypass_s bp;
      logic [DW-1:0] d;
      nx[i] = '0;
      d = (&srdy_reg[i] && xfer_reg[i] == '0 && dly_reg[i] != '0) ?
          DW'(dly_reg[i] - 1'b1) : dly_reg[i];
      for (int s = 0; s < NS; s++) begin
        hit[i][s] = valid_reg[i] && !srdy_reg[i][s] && tag_hit(stag_reg[i][s], bc_v, bc_tag);
        bp = dispatch_pkg::bypass_cost(sstk_reg[i][s], cstk_reg[i]);
        if (hit[i][s]) begin
          nx[i] = nx[i] | bp.xfer;
          if (bp.dly > d) d = bp.dly;
        end
      end
      dly_next[i] = d;
    end
  end

  // Same-cycle wake for the micro-op being allocated
  always_comb begin
    dispatch_pkg::bypass_s bp;
    anx = '0;
    adly = '0;
    for (int s = 0; s < NS; s++) begin
      ahit[s] = !alloc_src_rdy_i[s] && tag_hit(alloc_src_tag_i[s], bc_v, bc_tag);
      bp = dispatch_pkg::bypass_cost(alloc_src_stack_i[s], alloc_stack_i);
      if (ahit[s]) begin
        anx = anx | bp.xfer;
        if (bp.dly > adly) adly = bp.dly;
      end
    end
  end

  // Lowest free slot takes the next micro-op
  always_comb begin
    alloc_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!valid_reg[i]) alloc_idx = IDX_W'(i);
    end
  end
  assign do_alloc = alloc_valid_i && ready_reg && !flush_i;

  // ----------------------------------------------------------------
  // Port selection
  // ----------------------------------------------------------------
  // Ports served in turn so a slot issued on one port is gone for the next; a transfer grant leaves it open
  always_comb begin
    taken = '0;
    grant_v = '0;
    grant_x = '0;
    grant_idx = '0;
    cand = '0;
    for (int i = 0; i < DEPTH; i++) xclr[i] = '0;
    for (int p = 0; p < NP; p++) begin
      for (int i = 0; i < DEPTH; i++) begin
        cand[i] = valid_reg[i] && ((rdy_ent[i] && !taken[i] && ent_mask[i][p])
                  || xfer_reg[i][p]);
      end
      for (int i = 0; i < DEPTH; i++) begin
        if (cand[i] && (cand & older_reg[i]) == '0) begin
          grant_v[p] = !flush_i;
          grant_idx[p] = IDX_W'(i);
          grant_x[p] = xfer_reg[i][p];
        end
      end
      if (grant_v[p] && grant_x[p]) xclr[grant_idx[p]][p] = 1'b1;
      if (grant_v[p] && !grant_x[p]) taken[grant_idx[p]] = 1'b1;
    end
  end

  // Count of real issues this cycle
  always_comb begin
    ndisp = '0;
    for (int i = 0; i < DEPTH; i++) ndisp = ndisp + CNT_W'(taken[i]);
    cnt_next = CNT_W'(cnt_reg + CNT_W'(do_alloc) - ndisp);
  end

  // ----------------------------------------------------------------
  // Pool state
  // ----------------------------------------------------------------
  // Slot occupancy
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || flush_i) begin
      valid_reg <= '0;
    end else begin
      valid_reg <= valid_reg & ~taken;
      if (do_alloc) valid_reg[alloc_idx] <= 1'b1;
    end
  end

  // Fixed fields, written once on allocation
  always_ff @(posedge clk_i) begin
    if (do_alloc) begin
      cls_reg[alloc_idx] <= alloc_cls_i;
      cstk_reg[alloc_idx] <= alloc_stack_i;
      stag_reg[alloc_idx] <= alloc_src_tag_i;
      sstk_reg[alloc_idx] <= alloc_src_stack_i;
    end
  end

  // Operand arrival, pending transfers and bypass countdown
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || flush_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        srdy_reg[i] <= '0;
        xfer_reg[i] <= '0;
        dly_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        srdy_reg[i] <= srdy_reg[i] | hit[i];
        xfer_reg[i] <= (xfer_reg[i] & ~xclr[i]) | nx[i];
        dly_reg[i] <= dly_next[i];
      end
      if (do_alloc) begin
        srdy_reg[alloc_idx] <= alloc_src_rdy_i | ahit;
        xfer_reg[alloc_idx] <= anx;
        dly_reg[alloc_idx] <= adly;
      end
    end
  end

  // Age order: a new slot is younger than all live ones
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) older_reg[i] <= '0;
    end else if (do_alloc) begin
      for (int i = 0; i < DEPTH; i++) older_reg[i][alloc_idx] <= 1'b0;
      older_reg[alloc_idx] <= valid_reg & ~taken;
    end
  end

  // Occupancy and back-pressure toward rename
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || flush_i) begin
      cnt_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      ready_reg <= cnt_next != CNT_W'(DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Issue outputs and load wake pipe
  // ----------------------------------------------------------------
  // Payload read lands with the registered grant
  payload_store #(.WIDTH(PAY_W), .DEPTH(DEPTH), .RD_N(NP)) u_payload (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(do_alloc),
    .wr_addr_i(alloc_idx),
    .wr_data_i({alloc_cls_i, alloc_tag_i}),
    .rd_addr_i(grant_idx),
    .rd_data_o(rd_pay)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      port_valid_reg <= '0;
      port_xfer_reg <= '0;
    end else begin
      port_valid_reg <= grant_v;
      port_xfer_reg <= grant_v & grant_x;
    end
  end

  // Loads wake consumers early so use follows four cycles after issue
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || flush_i) begin
      for (int s = 0; s < LW; s++) begin
        ld_v_reg[s] <= '0;
        ld_tag_reg[s] <= '0;
      end
    end else begin
      for (int l = 0; l < dispatch_pkg::LOAD_PORTS; l++) begin
        ld_v_reg[0][l] <= port_valid_o[l == 0 ? dispatch_pkg::LOAD_PORT_A :
                          dispatch_pkg::LOAD_PORT_B] && !port_xfer_o[l == 0 ?
                          dispatch_pkg::LOAD_PORT_A : dispatch_pkg::LOAD_PORT_B] &&
                          port_cls_o[l == 0 ? dispatch_pkg::LOAD_PORT_A :
                          dispatch_pkg::LOAD_PORT_B] == dispatch_pkg::CLS_LOAD;
        ld_tag_reg[0][l] <= port_tag_o[l == 0 ? dispatch_pkg::LOAD_PORT_A :
                            dispatch_pkg::LOAD_PORT_B];
      end
      for (int s = 1; s < LW; s++) begin
        ld_v_reg[s] <= ld_v_reg[s-1];
        ld_tag_reg[s] <= ld_tag_reg[s-1];
      end
    end
  end

  assign alloc_ready_o = ready_reg;
  assign occupancy_o = cnt_reg;
  assign port_valid_o = port_valid_reg;
  assign port_xfer_o = port_xfer_reg;
  for (genvar p = 0; p < NP; p++) begin : g_out
    assign port_tag_o[p] = rd_pay[p][TAG_W-1:0];
    assign port_cls_o[p] = dispatch_pkg::op_cls_e'(rd_pay[p][PAY_W-1:TAG_W]);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FULL_STALL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cnt_reg == CNT_W'(DEPTH) |-> !alloc_ready_o) else $error("Pool full but accepting");

  AST_ALLOC_COUNT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    do_alloc && taken == '0 |=> cnt_reg == CNT_W'($past(cnt_reg) + 1'b1))
    else $error("Allocation not counted");

  AST_DISP_TOTAL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> $countones(port_valid_o & ~port_xfer_o) == $past(ndisp)
    && $countones(port_valid_o & ~port_xfer_o) <= dispatch_pkg::MAX_DISPATCH)
    else $error("Issue count mismatch");

  AST_FLUSH_EMPTY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    flush_i |=> cnt_reg == '0 && port_valid_o == '0 && alloc_ready_o)
    else $error("Flush left state behind");

  AST_XFER_PORT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (port_xfer_o & ~dispatch_pkg::XFER_PORTS) == '0 && (port_xfer_o & ~port_valid_o) == '0)
    else $error("Transfer on wrong port");

  for (genvar p = 0; p < NP; p++) begin : g_chk_port
    dispatch_pkg::port_mask_t pm_out;
    assign pm_out = dispatch_pkg::port_mask(port_cls_o[p]);
    AST_PORT_CLASS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      port_valid_o[p] && !port_xfer_o[p] |-> pm_out[p]) else $error("Class on wrong port");
    for (genvar q = p + 1; q < NP; q++) begin : g_pair
      AST_ONE_PORT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        grant_v[p] && grant_v[q] && !grant_x[p] && !grant_x[q] |-> grant_idx[p] != grant_idx[q])
        else $error("Micro-op on two ports");
    end
  end

  for (genvar l = 0; l < dispatch_pkg::LOAD_PORTS; l++) begin : g_chk_load
    localparam int LP = (l == 0) ? dispatch_pkg::LOAD_PORT_A : dispatch_pkg::LOAD_PORT_B;
    AST_LOAD_WAKE: assert property (@(posedge clk_i) disable iff (sys_rst_i || flush_i)
      port_valid_o[LP] && !port_xfer_o[LP] && port_cls_o[LP] == dispatch_pkg::CLS_LOAD
      |-> ##LW bc_v[WB_N + l] && bc_tag[WB_N + l] == $past(port_tag_o[LP], LW))
      else $error("Load wake not on time");
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_chk_dly
    AST_DLY_STEP: assert property (@(posedge clk_i) disable iff (sys_rst_i || flush_i)
      valid_reg[i] && &srdy_reg[i] && xfer_reg[i] == '0 && dly_reg[i] != '0
      |-> !taken[i] ##1 dly_reg[i] == DW'($past(dly_reg[i]) - 1'b1))
      else $error("Bypass delay not counted");
  end

endmodule // uop_dispatch_port_scheduler

// file: tb/exec_model.sv
`timescale 1ns/1ps
// ---
// Execution cluster: returns the lowest-port real issue of each cycle as a writeback
// ---
module exec_model #(
  parameter int TAG_W = 7
) (
  input wire logic clk_i,                        // Core clock
  input wire logic sys_rst_i,                    // Sync reset
  input wire logic [7:0] port_valid_i,           // Issues
  input wire logic [7:0] port_xfer_i,            // Transfer flags
  input wire logic [7:0][TAG_W-1:0] port_tag_i,  // Issued tags
  output logic wb_valid_o,                       // Result written
  output logic [TAG_W-1:0] wb_tag_o              // Its tag
);
  // One lane only, lowest port wins; transfers carry no result.
  // Idle lane flips its tag so a stale value never looks valid.
  always_ff @(posedge clk_i) begin
    wb_valid_o <= 1'b0;
    if (sys_rst_i) begin
      wb_tag_o <= '0;
    end else begin
      wb_tag_o <= ~wb_tag_o;
      for (int p = 7; p >= 0; p--) begin
        if (port_valid_i[p] && !port_xfer_i[p]) begin
          wb_valid_o <= 1'b1;
          wb_tag_o <= port_tag_i[p];
        end
      end
    end
  end
endmodule // exec_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int TW = dispatch_pkg::TAG_W_DEF;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic flush_i = 1'b0;
  logic alloc_valid_i = 1'b0;
  logic ready;
  dispatch_pkg::op_cls_e cls = dispatch_pkg::CLS_ALU;
  dispatch_pkg::stack_e stk = dispatch_pkg::STK_INT;
  dispatch_pkg::stack_e src_stk [2] = '{dispatch_pkg::STK_INT, dispatch_pkg::STK_INT};
  logic [TW-1:0] tag = '0;
  logic [1:0][TW-1:0] src_tag = '0;
  logic [1:0] src_rdy = 2'b11;
  logic tb_v = 1'b0;
  logic [TW-1:0] tb_t = '0;
  logic m_v;
  logic [TW-1:0] m_t;
  logic [7:0] pv;
  logic [7:0] px;
  logic [7:0][TW-1:0] ptag;
  dispatch_pkg::op_cls_e pcls [8];
  logic [6:0] occ;
  int bad_count = 0;
  int num_checks = 0;
  int n;
  // Row i is class i in enum order, value is its lowest legal port
  int exp_idx [20] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 4, 0, 0, 1, 5, 5, 5, 0, 0, 1, 0};

  // ---
  // Clock, design and partner
  // ---
  initial forever #12.5 clk_i = ~clk_i;
  uop_dispatch_port_scheduler u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .flush_i(flush_i),
    .alloc_valid_i(alloc_valid_i), .alloc_ready_o(ready), .alloc_cls_i(cls),
    .alloc_stack_i(stk), .alloc_tag_i(tag), .alloc_src_tag_i(src_tag),
    .alloc_src_stack_i(src_stk), .alloc_src_rdy_i(src_rdy), .wb_valid_i({2'b00, tb_v, m_v}),
    .wb_tag_i({{(2*TW){1'b0}}, tb_t, m_t}), .port_valid_o(pv), .port_xfer_o(px),
    .port_tag_o(ptag), .port_cls_o(pcls), .occupancy_o(occ));
  exec_model #(.TAG_W(TW)) u_exec (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port_valid_i(pv),
    .port_xfer_i(px), .port_tag_i(ptag), .wb_valid_o(m_v), .wb_tag_o(m_t));

  // ---
  // Shared tasks
  // ---
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Offer held one edge, then released at the next falling edge
  task automatic offer(input dispatch_pkg::op_cls_e c, input int t, input logic [1:0] r);
    @(negedge clk_i);
    cls = c;
    tag = TW'(t);
    src_rdy = r;
    alloc_valid_i = 1'b1;
    @(negedge clk_i);
    alloc_valid_i = 1'b0;
  endtask
  task automatic pulse_wb(input int t);
    @(negedge clk_i);
    tb_v = 1'b1;
    tb_t = TW'(t);
    @(negedge clk_i);
    tb_v = 1'b0;
  endtask
  // Producer in stack f feeds a port-0 consumer in stack t
  task automatic bypass(input dispatch_pkg::stack_e f, input dispatch_pkg::stack_e t,
                        input dispatch_pkg::op_cls_e c, input logic [7:0] xm, input int rn);
    repeat (4) @(negedge clk_i);
    stk = t;
    src_stk[0] = f;
    src_tag[0] = TW'(8'h11);
    offer(c, 8'h50, 2'b10);
    pulse_wb(8'h11);
    for (int k = 1; k <= rn; k++) begin
      @(negedge clk_i);
      if (k == rn) chk({px, pv}, 16'h0001);
      else if (k == 1) chk({px, pv}, {xm, xm});
      else chk({8'h00, pv}, 16'h0000);
    end
  endtask

  // ---
  // Main sequence
  // ---
  initial begin
    repeat (2) @(negedge clk_i);
    chk({ready, 8'h00, occ}, 16'h8000);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 20; i++) begin
      offer(dispatch_pkg::op_cls_e'(i), 8'h30 + i, 2'b11);
      n = 0;
      while (pv === 8'h00 && n < 20) begin
        @(negedge clk_i);
        n++;
      end
      if (n >= 20) begin
        bad_count++;
        print_verdict();
      end
      chk(16'(n), 16'h0001);
      chk({8'h00, pv}, 16'(8'h01 << exp_idx[i]));
      chk(16'(pcls[exp_idx[i]]), 16'(i));
      chk(16'(ptag[exp_idx[i]]), 16'(8'h30 + i));
    end
    // Fill every slot with ops that wait on a tag nobody writes
    src_tag = {TW'(8'h7F), TW'(8'h7F)};
    for (int i = 0; i < 60; i++) offer(dispatch_pkg::CLS_ALU, i, 2'b00);
    chk({ready, 8'h00, occ}, 16'h003C);
    offer(dispatch_pkg::CLS_ALU, 8'h3C, 2'b00);
    chk({ready, 8'h00, occ}, 16'h003C);
    @(negedge clk_i);
    flush_i = 1'b1;
    @(negedge clk_i);
    flush_i = 1'b0;
    chk({ready, 8'h00, occ}, 16'h8000);
    // Five ALU ops woken by one writeback compete for four ports
    for (int i = 0; i < 5; i++) offer(dispatch_pkg::CLS_ALU, 8'h20 + i, 2'b10);
    pulse_wb(8'h7F);
    @(negedge clk_i);
    chk({8'h00, pv}, 16'h0063);
    chk({1'b0, ptag[0], 1'b0, ptag[1]}, 16'h2021);
    chk({1'b0, ptag[5], 1'b0, ptag[6]}, 16'h2223);
    @(negedge clk_i);
    chk({1'b0, ptag[0], pv}, 16'h2401);
    bypass(dispatch_pkg::STK_INT, dispatch_pkg::STK_VEC_INT, dispatch_pkg::CLS_VEC_LOGIC,
           8'h60, 3);
    bypass(dispatch_pkg::STK_LEGACY_FP, dispatch_pkg::STK_INT, dispatch_pkg::CLS_ALU,
           8'h02, 5);
    bypass(dispatch_pkg::STK_INT, dispatch_pkg::STK_LEGACY_FP, dispatch_pkg::CLS_FMA,
           8'h20, 5);
    bypass(dispatch_pkg::STK_VEC_INT, dispatch_pkg::STK_VEC_FP_LOW, dispatch_pkg::CLS_FMA,
           8'h00, 2);
    print_verdict();
  end
endmodule // testbench
